// file: mfm_pkg.sv
// Shared constants and carrier types for the multiframe maintenance messaging block.
// Assumes one 200 MHz clock and multiframe timing strobes from the framing logic.
package mfm_pkg;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned MF_PER_SIX = 6;
  localparam logic [2:0] MF_LAST_IN_SIX = 3'h5;
  localparam logic [1:0] VALID_COUNT = 2'h3;
  localparam logic [4:0] FRAMES_PER_MF = 5'h14;
  localparam logic [3:0] IDLE_NT_WORD = 4'h0;
  localparam logic [3:0] IDLE_TE_WORD = 4'hf;
  localparam logic [3:0] WORD_POWER_LOSS = 4'hf;
  localparam logic [3:0] WORD_POWER_LOSS_Q = 4'h0;
  localparam logic [3:0] WORD_FAR_END_VIOL = 4'he;
  localparam logic [3:0] WORD_SELF_TEST_PASS = 4'h2;
  localparam logic [3:0] WORD_SELF_TEST_FAIL = 4'h1;
  localparam logic [3:0] WORD_DISRUPTIVE = 4'h3;
  localparam logic [3:0] WORD_IDLE_SC1 = 4'h0;
  localparam logic [3:0] WORD_LOSS_SIGNAL = 4'ha;
  localparam logic [3:0] WORD_Q_SELF_TEST = 4'h1;
  localparam logic [3:0] WORD_Q_LB1 = 4'h7;
  localparam logic [3:0] WORD_Q_LB2 = 4'hb;
  localparam logic [3:0] WORD_Q_LB12 = 4'h3;
  localparam logic [3:0] WORD_Q_IDLE = 4'hf;
  localparam logic [1:0] HP_DEPTH = 2'h2;

  // Received multiframe words: the sc1q word and the sc2 word of that multiframe.
  typedef struct packed {
    logic [3:0] sc1q;
    logic [3:0] sc2;
  } mfm_rx_s;

  typedef enum logic {MFM_NT, MFM_TE} mfm_mode_e;
endpackage : mfm_pkg

// file: mfm_rx_check.sv
// Receive word checker: validates one 4-bit maintenance word per multiframe.
// Assumes mf_end pulses once per multiframe with the word valid on that cycle.
`timescale 1ns/100ps
module mfm_rx_check (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic mf_end,
  input wire logic [3:0] word,
  input wire logic validate,
  input wire logic needs_three,
  output logic raise
);
  logic [3:0] last_word;
  logic [1:0] same_count;
  logic reported;
  logic changed;

  assign changed = (word != last_word);

  // History of the previous word and run length of identical receptions.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      last_word <= 4'h0;
      same_count <= 2'h0;
    end
    else if (mf_end)
    begin
      last_word <= word;
      if (changed)
        same_count <= 2'h1;
      else if (same_count != mfm_pkg::VALID_COUNT)
        same_count <= same_count + 2'h1;
    end
  end

  // One report per word: repeats stay silent until the word changes.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      raise <= 1'b0;
      reported <= 1'b0;
    end
    else
    begin
      raise <= 1'b0;
      if (mf_end)
      begin
        if (!validate)
        begin
          raise <= changed;
          reported <= 1'b0;
        end
        else if (changed)
        begin
          raise <= !needs_three;
          reported <= !needs_three;
        end
        else if (!reported && (!needs_three || same_count == 2'h2))
        begin
          raise <= 1'b1;
          reported <= 1'b1;
        end
      end
    end
  end

  a_change_raise: assert property (@(posedge sys_clk) disable iff (srst)
    (mf_end && !validate && changed) |=> raise) else $error("change not reported");

  a_three_wait: assert property (@(posedge sys_clk) disable iff (srst)
    (mf_end && validate && needs_three && changed) |=> !raise) else $error("threefold word reported early");
endmodule : mfm_rx_check

// file: mfm_top.sv
// Multiframe maintenance messaging: transmit word selection, receive checks, error detector.
// Assumes framing logic supplies frame and multiframe strobes and violation flags.
`timescale 1ns/100ps
module mfm_top (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic te_mode,
  input wire logic frame_start,
  input wire logic q_frame,
  input wire logic mf_boundary,
  input wire logic code_violation,
  input wire logic balance_error,
  input wire mfm_pkg::mfm_rx_s rx_word,
  input wire logic high_priority_load,
  input wire logic [3:0] high_priority_tx_word,
  input wire logic low_priority_load,
  input wire logic [3:0] low_priority_tx_word,
  input wire logic second_load,
  input wire logic [3:0] second_subchannel_tx_word,
  input wire logic six_multiframe_count_enable,
  input wire logic single_multiframe_count_enable,
  input wire logic validation_enable_command,
  input wire logic validation_disable_command,
  input wire logic interrupt_unmask_command,
  input wire logic irq_read,
  output logic [3:0] tx_sc1q_word,
  output logic [3:0] tx_sc2_word,
  output logic high_priority_full,
  output logic primary_word_received_irq,
  output logic second_subchannel_received_irq,
  output logic multiframe_error_irq,
  output logic multiframe_count_irq
);
  logic [3:0] hp_slot [2];
  logic [1:0] hp_count;
  logic [3:0] lp_word;
  logic [3:0] sc2_word;
  logic [2:0] six_count;
  logic validate;
  logic err_unmasked;
  logic mf_had_error;
  logic primary_raise;
  logic second_raise;
  logic primary_three;
  logic next_err_hit;
  logic hp_take;

  // ---------------------------------------------------------------
  // Controller settings
  // ---------------------------------------------------------------

  // Validation mode and error mask; disable wins over a same-cycle enable.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      validate <= 1'b0;
      err_unmasked <= 1'b0;
    end
    else
    begin
      if (validation_disable_command)
        validate <= 1'b0;
      else if (validation_enable_command)
        validate <= 1'b1;
      if (interrupt_unmask_command)
        err_unmasked <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Transmit words
  // ---------------------------------------------------------------

  assign hp_take = mf_boundary && (hp_count != 2'h0);
  assign high_priority_full = (hp_count == mfm_pkg::HP_DEPTH);

  // two-deep high queue
  // Loads when full are dropped so an older one-shot is never overwritten.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      hp_count <= 2'h0;
      hp_slot[0] <= 4'h0;
      hp_slot[1] <= 4'h0;
    end
    else
    begin
      if (hp_take)
        hp_slot[0] <= hp_slot[1];
      if (high_priority_load && !high_priority_full)
        hp_slot[(hp_count - {1'b0, hp_take}) == 2'h0 ? 0 : 1] <= high_priority_tx_word;
      hp_count <= hp_count + {1'b0, high_priority_load && !high_priority_full} - {1'b0, hp_take};
    end
  end

  // Low-priority word holds until the controller replaces it.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      lp_word <= mfm_pkg::IDLE_NT_WORD;
    else if (low_priority_load)
      lp_word <= low_priority_tx_word;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      tx_sc1q_word <= mfm_pkg::IDLE_NT_WORD;
    else if (mf_boundary)
      tx_sc1q_word <= hp_take ? hp_slot[0] : lp_word;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      six_count <= 3'h0;
    else if (mf_boundary)
      six_count <= (six_count == mfm_pkg::MF_LAST_IN_SIX) ? 3'h0 : six_count + 3'h1;
  end

  // SC2 word latched only on six-boundaries while six-count is on and single-count off, so a word is sent six times; else every multiframe.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      sc2_word <= 4'h0;
      tx_sc2_word <= 4'h0;
    end
    else
    begin
      if (second_load)
        sc2_word <= second_subchannel_tx_word;
      if (mf_boundary && (six_count == 3'h0 || single_multiframe_count_enable || !six_multiframe_count_enable))
        tx_sc2_word <= sc2_word;
    end
  end

  // ---------------------------------------------------------------
  // Receive validation
  // ---------------------------------------------------------------

  always_comb
  begin
    if (te_mode)
      primary_three = (rx_word.sc1q == mfm_pkg::WORD_SELF_TEST_PASS) ||
                      (rx_word.sc1q == mfm_pkg::WORD_SELF_TEST_FAIL) ||
                      (rx_word.sc1q == mfm_pkg::WORD_DISRUPTIVE) ||
                      (rx_word.sc1q == mfm_pkg::WORD_IDLE_SC1) ||
                      (rx_word.sc1q == mfm_pkg::WORD_LOSS_SIGNAL);
    else
      primary_three = (rx_word.sc1q == mfm_pkg::WORD_Q_SELF_TEST) ||
                      (rx_word.sc1q == mfm_pkg::WORD_Q_LB1) ||
                      (rx_word.sc1q == mfm_pkg::WORD_Q_LB2) ||
                      (rx_word.sc1q == mfm_pkg::WORD_Q_LB12) ||
                      (rx_word.sc1q == mfm_pkg::WORD_Q_IDLE);
  end

  mfm_rx_check u_primary (
    .sys_clk(sys_clk),
    .srst(srst),
    .mf_end(mf_boundary),
    .word(rx_word.sc1q),
    .validate(validate),
    .needs_three(primary_three),
    .raise(primary_raise)
  );

  mfm_rx_check u_second (
    .sys_clk(sys_clk),
    .srst(srst),
    .mf_end(mf_boundary),
    .word(rx_word.sc2),
    .validate(validate),
    .needs_three(1'b1),
    .raise(second_raise)
  );

  // ---------------------------------------------------------------
  // Multiframe error detector
  // ---------------------------------------------------------------

  assign next_err_hit = balance_error || (code_violation && (te_mode || !q_frame));

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      mf_had_error <= 1'b0;
    else if (mf_boundary)
      mf_had_error <= 1'b0; // A hit on the boundary belongs to the ending multiframe, counted below.
    else if (next_err_hit)
      mf_had_error <= 1'b1;
  end

  // ---------------------------------------------------------------
  // Interrupt flags
  // ---------------------------------------------------------------

  // read clears
  // A new event in the read cycle wins, so nothing is lost.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      primary_word_received_irq <= 1'b0;
      second_subchannel_received_irq <= 1'b0;
      multiframe_error_irq <= 1'b0;
      multiframe_count_irq <= 1'b0;
    end
    else
    begin
      primary_word_received_irq <= primary_raise || (primary_word_received_irq && !irq_read);
      second_subchannel_received_irq <= second_raise || (second_subchannel_received_irq && !irq_read);
      multiframe_error_irq <= (mf_boundary && (mf_had_error || next_err_hit) && err_unmasked) ||
                              (multiframe_error_irq && !irq_read);
      multiframe_count_irq <= (mf_boundary && (single_multiframe_count_enable ||
                              (six_multiframe_count_enable && six_count == mfm_pkg::MF_LAST_IN_SIX))) ||
                              (multiframe_count_irq && !irq_read);
    end
  end

  a_error_masked: assert property (@(posedge sys_clk) disable iff (srst)
    !err_unmasked |=> !multiframe_error_irq) else $error("error irq while masked");

  a_high_then_low: assert property (@(posedge sys_clk) disable iff (srst)
    (mf_boundary && hp_count == 2'h0 && !low_priority_load) |=> tx_sc1q_word == $past(lp_word))
    else $error("low word not sent");

  a_flag_holds: assert property (@(posedge sys_clk) disable iff (srst)
    (primary_word_received_irq && !irq_read) |=> primary_word_received_irq)
    else $error("primary flag lost");

  a_queue_bound: assert property (@(posedge sys_clk) disable iff (srst)
    hp_count <= mfm_pkg::HP_DEPTH) else $error("high queue overflow");

  a_one_shot: assert property (@(posedge sys_clk) disable iff (srst)
    hp_take |=> tx_sc1q_word == $past(hp_slot[0])) else $error("high word not sent");

  a_sc2_six: assert property (@(posedge sys_clk) disable iff (srst)
    (mf_boundary && six_multiframe_count_enable && !single_multiframe_count_enable && six_count != 3'h0)
    |=> $stable(tx_sc2_word)) else $error("sc2 word changed mid period");

  a_error_flag: assert property (@(posedge sys_clk) disable iff (srst)
    (mf_boundary && err_unmasked && mf_had_error) |=> multiframe_error_irq)
    else $error("error irq missing");

  a_count_single: assert property (@(posedge sys_clk) disable iff (srst)
    (mf_boundary && single_multiframe_count_enable) |=> multiframe_count_irq)
    else $error("count irq missing");
endmodule : mfm_top

// file: mfm_peer.sv
// Line peer model: frames each multiframe and delivers received words and error pulses.
// Assumes the bench sets the peer's words and picks which error, if any, to inject.
`timescale 1ns/100ps
module mfm_peer (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [3:0] peer_sc1q,
  input wire logic [3:0] peer_sc2,
  input wire logic [1:0] inject,
  output logic frame_start,
  output logic q_frame,
  output logic mf_boundary,
  output logic code_violation,
  output logic balance_error,
  output mfm_pkg::mfm_rx_s rx_word
);
  logic [1:0] bit_cnt;
  logic [4:0] frame_cnt;
  // Four clocks a frame keeps a multiframe at 80 cycles, short enough for many passes.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      bit_cnt <= 2'h0;
      frame_cnt <= 5'h00;
    end
    else
    begin
      bit_cnt <= bit_cnt + 2'h1;
      if (bit_cnt == 2'h3)
        frame_cnt <= (frame_cnt == 5'h13) ? 5'h00 : frame_cnt + 5'h01;
    end
  end
  // Every fifth frame carries Q data; the word is inverted off the boundary so stale data never matches.
  assign frame_start = (bit_cnt == 2'h0);
  assign q_frame = (frame_cnt % 5'h05 == 5'h00);
  assign mf_boundary = (bit_cnt == 2'h3) && (frame_cnt == 5'h13);
  assign rx_word = mf_boundary ? {peer_sc1q, peer_sc2} : ~{peer_sc1q, peer_sc2};
  // Inject 1 is a code error in a plain frame, 2 one in a Q frame, 3 a balance error in a Q frame.
  assign code_violation = (bit_cnt == 2'h1) && ((inject == 2'h1 && frame_cnt == 5'h02) ||
                          (inject == 2'h2 && frame_cnt == 5'h05));
  assign balance_error = (bit_cnt == 2'h1) && (inject == 2'h3) && (frame_cnt == 5'h05);
endmodule : mfm_peer

// file: mfm_top_bench.sv
// Self-checking bench for the maintenance messaging block, driven at the falling edge.
// Assumes the line peer model supplies framing; every controller input comes from the scenario tasks.
`timescale 1ns/100ps
module mfm_top_bench;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic te_mode = 1'b0;
  logic high_priority_load = 1'b0;
  logic [3:0] high_priority_tx_word = 4'h0;
  logic low_priority_load = 1'b0;
  logic [3:0] low_priority_tx_word = 4'h0;
  logic second_load = 1'b0;
  logic [3:0] second_subchannel_tx_word = 4'h0;
  logic six_multiframe_count_enable = 1'b0;
  logic single_multiframe_count_enable = 1'b0;
  logic validation_enable_command = 1'b0;
  logic validation_disable_command = 1'b0;
  logic interrupt_unmask_command = 1'b0;
  logic irq_read = 1'b0;
  logic [3:0] peer_sc1q = 4'h0;
  logic [3:0] peer_sc2 = 4'h0;
  logic [1:0] inject = 2'h0;
  logic frame_start, q_frame, mf_boundary, code_violation, balance_error;
  mfm_pkg::mfm_rx_s rx_word;
  logic [3:0] tx_sc1q_word, tx_sc2_word;
  logic high_priority_full, primary_word_received_irq, second_subchannel_received_irq;
  logic multiframe_error_irq, multiframe_count_irq;
  int n_mismatch = 0;
  int n_compared = 0;
  // Half period of 2.5 ns gives the 200 MHz clock.
  always #2.5 sys_clk = ~sys_clk;
  mfm_peer i_mfm_peer (.sys_clk, .srst, .peer_sc1q, .peer_sc2, .inject, .frame_start, .q_frame,
    .mf_boundary, .code_violation, .balance_error, .rx_word);
  mfm_top i_mfm_top (.sys_clk, .srst, .te_mode, .frame_start, .q_frame, .mf_boundary, .code_violation,
    .balance_error, .rx_word, .high_priority_load, .high_priority_tx_word, .low_priority_load,
    .low_priority_tx_word, .second_load, .second_subchannel_tx_word, .six_multiframe_count_enable,
    .single_multiframe_count_enable, .validation_enable_command, .validation_disable_command,
    .interrupt_unmask_command, .irq_read, .tx_sc1q_word, .tx_sc2_word, .high_priority_full,
    .primary_word_received_irq, .second_subchannel_received_irq, .multiframe_error_irq,
    .multiframe_count_irq);
  // --------------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------------
  task automatic close_out();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [3:0] exp, input logic [3:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Returns two cycles after a boundary, once the registered answers have landed.
  task automatic wait_mf(input int n);
    int t;
    repeat (n)
    begin
      t = 0;
      @(negedge sys_clk);
      while (mf_boundary !== 1'b1 && t < 200)
      begin
        @(negedge sys_clk);
        t++;
      end
      if (t >= 200)
      begin
        n_mismatch++;
        close_out();
      end
      repeat (2) @(negedge sys_clk);
    end
  endtask : wait_mf
  task automatic rd();
    irq_read = 1'b1;
    @(negedge sys_clk);
    irq_read = 1'b0;
    @(negedge sys_clk);
  endtask : rd
  task automatic load(input logic hi, input logic [3:0] w);
    high_priority_tx_word = w;
    low_priority_tx_word = w;
    high_priority_load = hi;
    low_priority_load = !hi;
    @(negedge sys_clk);
    high_priority_load = 1'b0;
    low_priority_load = 1'b0;
    @(negedge sys_clk);
  endtask : load
  // Error is injected for one whole multiframe, then the flag is judged and read away.
  task automatic err_case(input logic [1:0] inj, input logic exp);
    inject = inj;
    wait_mf(1);
    inject = 2'h0;
    chk("error irq", {3'h0, exp}, {3'h0, multiframe_error_irq});
    rd();
  endtask : err_case
  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic t_nt_tx();
    load(1'b0, 4'h5);
    load(1'b1, mfm_pkg::WORD_FAR_END_VIOL);
    load(1'b1, mfm_pkg::WORD_LOSS_SIGNAL);
    chk("hp full", 4'h1, {3'h0, high_priority_full});
    wait_mf(1);
    chk("sc1 first", mfm_pkg::WORD_FAR_END_VIOL, tx_sc1q_word);
    wait_mf(1);
    chk("sc1 second", mfm_pkg::WORD_LOSS_SIGNAL, tx_sc1q_word);
    wait_mf(1);
    chk("sc1 low", 4'h5, tx_sc1q_word);
    $display("test nt_tx done");
  endtask : t_nt_tx
  task automatic t_nt_err();
    wait_mf(1);
    rd();
    err_case(2'h1, 1'b0);
    interrupt_unmask_command = 1'b1;
    @(negedge sys_clk);
    interrupt_unmask_command = 1'b0;
    err_case(2'h2, 1'b0);
    err_case(2'h3, 1'b1);
    err_case(2'h1, 1'b1);
    chk("error cleared", 4'h0, {3'h0, multiframe_error_irq});
    load(1'b1, mfm_pkg::WORD_FAR_END_VIOL);
    wait_mf(1);
    chk("sc1 far end", mfm_pkg::WORD_FAR_END_VIOL, tx_sc1q_word);
    wait_mf(1);
    chk("sc1 reverts", 4'h5, tx_sc1q_word);
    $display("test nt_err done");
  endtask : t_nt_err
  task automatic t_te();
    te_mode = 1'b1;
    validation_enable_command = 1'b1;
    @(negedge sys_clk);
    validation_enable_command = 1'b0;
    load(1'b0, mfm_pkg::WORD_Q_LB1);
    load(1'b1, mfm_pkg::WORD_POWER_LOSS_Q);
    wait_mf(1);
    chk("q power loss", mfm_pkg::WORD_POWER_LOSS_Q, tx_sc1q_word);
    wait_mf(1);
    chk("q low", mfm_pkg::WORD_Q_LB1, tx_sc1q_word);
    load(1'b0, mfm_pkg::WORD_POWER_LOSS_Q);
    wait_mf(1);
    chk("q loss kept", mfm_pkg::WORD_POWER_LOSS_Q, tx_sc1q_word);
    wait_mf(1);
    rd();
    peer_sc1q = mfm_pkg::WORD_FAR_END_VIOL;
    wait_mf(1);
    chk("far end once", 4'h1, {3'h0, primary_word_received_irq});
    rd();
    peer_sc1q = mfm_pkg::WORD_SELF_TEST_PASS;
    peer_sc2 = 4'h5;
    wait_mf(2);
    chk("pass twice", 4'h0, {3'h0, primary_word_received_irq});
    chk("sc2 twice", 4'h0, {3'h0, second_subchannel_received_irq});
    wait_mf(1);
    chk("pass thrice", 4'h1, {3'h0, primary_word_received_irq});
    chk("sc2 thrice", 4'h1, {3'h0, second_subchannel_received_irq});
    rd();
    wait_mf(1);
    chk("no repeat", 4'h0, {3'h0, primary_word_received_irq});
    validation_disable_command = 1'b1;
    @(negedge sys_clk);
    validation_disable_command = 1'b0;
    peer_sc1q = mfm_pkg::WORD_DISRUPTIVE;
    wait_mf(1);
    chk("change irq", 4'h1, {3'h0, primary_word_received_irq});
    err_case(2'h2, 1'b1);
    single_multiframe_count_enable = 1'b1;
    wait_mf(1);
    chk("count irq", 4'h1, {3'h0, multiframe_count_irq});
    $display("test te done");
  endtask : t_te
  // Six-count cycle: find the period edge, then watch one SC2 word held six times and the next take over.
  task automatic t_sc2();
    int k;
    single_multiframe_count_enable = 1'b0;
    six_multiframe_count_enable = 1'b1;
    rd();
    k = 0;
    wait_mf(1);
    while (multiframe_count_irq !== 1'b1 && k < 6)
    begin
      wait_mf(1);
      k++;
    end
    chk("count six", 4'h1, {3'h0, multiframe_count_irq});
    rd();
    second_subchannel_tx_word = 4'h9;
    second_load = 1'b1;
    @(negedge sys_clk);
    second_load = 1'b0;
    wait_mf(1);
    chk("sc2 start", 4'h9, tx_sc2_word);
    second_subchannel_tx_word = 4'h6;
    second_load = 1'b1;
    @(negedge sys_clk);
    second_load = 1'b0;
    wait_mf(5);
    chk("sc2 six times", 4'h9, tx_sc2_word);
    chk("count period", 4'h1, {3'h0, multiframe_count_irq});
    rd();
    wait_mf(1);
    chk("sc2 next word", 4'h6, tx_sc2_word);
    wait_mf(6);
    chk("sc2 resent", 4'h6, tx_sc2_word);
    $display("test sc2 done");
  endtask : t_sc2
  // Main sequence: two-cycle reset, then each scenario in turn.
  initial
  begin
    repeat (2) @(negedge sys_clk);
    srst = 1'b0;
    chk("error irq reset", 4'h0, {3'h0, multiframe_error_irq});
    t_nt_tx();
    t_nt_err();
    t_te();
    t_sc2();
    close_out();
  end
endmodule : mfm_top_bench
